// >>> logic/swire_pkg.sv
// Purpose: Constants shared by both ends of the single-wire link
// Assumes: 10 MHz clock, 100 ns period
// Notes:   Times kept in their own units; cycle counts derived
package swire_pkg;
    localparam int CLK_KHZ = 10000;
    localparam int CLK_NS  = 100;
    // Host-side figures, us
    localparam int HOST_ONE_LOW_US   = 20;
    localparam int HOST_ZERO_LOW_US  = 115;
    localparam int HOST_BIT_PERIOD_US = 220;
    // Device-side figures, us (nominal)
    localparam int DEVICE_ONE_LOW_US   = 41;
    localparam int DEVICE_ZERO_LOW_US  = 111;
    localparam int DEVICE_BIT_PERIOD_US = 207;
    localparam int DEVICE_REPLY_DELAY_US = 222;
    // Filter window, ns
    localparam int START_PULSE_FILTER_WINDOW_NS = 1980;
    // Threshold between one and zero classes, us
    localparam int BIT_THRESHOLD_US = 68;
    // Low time above the longest host zero marks a break, us
    localparam int BREAK_DETECT_US  = 168;
    // Power sequencing
    localparam int GLOBAL_CORE_RESET_MS   = 4;
    localparam int POWER_ON_READY_DELAY_MS = 35;
    localparam int SLEEP_WAKE_DELAY_US    = 200;
    localparam int SHUTDOWN_WAKE_DELAY_MS = 20;
    localparam int SHUTDOWN_DELAY_MS      = 2000;
    localparam int BREAK_US               = 200;

    localparam int HOST_ONE_LOW_CYC    = HOST_ONE_LOW_US * 1000 / CLK_NS;
    localparam int HOST_ZERO_LOW_CYC   = HOST_ZERO_LOW_US * 1000 / CLK_NS;
    localparam int HOST_BIT_PERIOD_CYC = HOST_BIT_PERIOD_US * 1000 / CLK_NS;
    localparam int DEV_ONE_LOW_CYC     = DEVICE_ONE_LOW_US * 1000 / CLK_NS;
    localparam int DEV_ZERO_LOW_CYC    = DEVICE_ZERO_LOW_US * 1000 / CLK_NS;
    localparam int DEV_BIT_PERIOD_CYC  = DEVICE_BIT_PERIOD_US * 1000 / CLK_NS;
    localparam int DEV_REPLY_DELAY_CYC = DEVICE_REPLY_DELAY_US * 1000 / CLK_NS;
    // Longest filter rounds down
    localparam int FILTER_CYC          = START_PULSE_FILTER_WINDOW_NS / CLK_NS;
    localparam int BIT_THRESHOLD_CYC   = BIT_THRESHOLD_US * 1000 / CLK_NS;
    localparam int BREAK_DETECT_CYC    = BREAK_DETECT_US * 1000 / CLK_NS;
    localparam int SLEEP_WAKE_CYC      = SLEEP_WAKE_DELAY_US * 1000 / CLK_NS;
    localparam int BREAK_CYC           = BREAK_US * 1000 / CLK_NS;
    localparam int GLOBAL_RESET_CYC_DEF = GLOBAL_CORE_RESET_MS * 1000000 / CLK_NS;
    localparam int POR_READY_CYC_DEF   = POWER_ON_READY_DELAY_MS * 1000000 / CLK_NS;
    localparam int SHUTDOWN_WAKE_CYC_DEF = SHUTDOWN_WAKE_DELAY_MS * 1000000 / CLK_NS;
    localparam int SHUTDOWN_CYC_DEF    = SHUTDOWN_DELAY_MS * 1000 / CLK_NS * 1000;

    localparam int CNT_W  = 32;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int BYTE_BITS  = 8;
    localparam int DIR_BIT    = 7;
endpackage

// >>> logic/swire_if.sv
// Purpose: Shared open-drain wire between host and device ends
// Assumes: Passive pull-up; line low when either end drives
// Notes:   Resolves level from output enables
`timescale 1ns/1ps
`default_nettype none
interface swire_if;
    logic host_oe;
    logic dev_oe;
    logic line;
    assign line = ~(host_oe | dev_oe);
    modport host (output host_oe, input line);
    modport dev  (output dev_oe, input line);
endinterface
`default_nettype wire

// >>> logic/swire_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module swire_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_mclk,    // Clock
    input  wire logic             i_rst,     // Sync reset
    input  wire logic [WIDTH-1:0] i_data,    // Write data
    input  wire logic             i_valid,   // Write valid
    output logic                  o_ready,   // Not full
    output logic [WIDTH-1:0]      o_data,    // Read data
    output logic                  o_valid,   // Not empty
    input  wire logic             i_ready    // Read accept
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fifo_s;
    fifo_s st_r, st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign o_valid = st_r.wp != st_r.rp;
    assign o_ready = !((st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]));
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_data  = mem[st_r.rp[AW-1:0]];

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
        if (push) begin
            mem[st_r.wp[AW-1:0]] <= i_data;
        end
    end
endmodule
`default_nettype wire

// >>> logic/swire_device.sv
// Purpose: Device end of the single-wire return-to-one link
// Assumes: 10 MHz clock stands in for the fast internal oscillator
// Notes:   Reply bytes pass through a 16-word FIFO
`timescale 1ns/1ps
`default_nettype none
module swire_device #(
    parameter int GLOBAL_RESET_CYC = swire_pkg::GLOBAL_RESET_CYC_DEF,
    parameter int SHUTDOWN_CYC     = swire_pkg::SHUTDOWN_CYC_DEF
) (
    input  wire logic       i_mclk,         // Clock
    input  wire logic       i_rst,          // Power-on reset
    swire_if.dev            bus,            // Shared wire
    input  wire logic       i_asd_met,      // Auto-shutdown supply threshold met
    input  wire logic [7:0] i_reply_data,   // Reply byte from core
    input  wire logic       i_reply_valid,  // Reply byte offered
    output logic            o_reply_ready,  // Reply FIFO has room
    output logic            o_global_core_reset, // Core held in reset
    output logic [7:0]      o_cmd,          // Received command byte
    output logic [7:0]      o_wdata,        // Received write data
    output logic            o_cmd_valid,    // Command received pulse
    output logic            o_wdata_valid,  // Write data received pulse
    output logic            o_shutdown      // Shutdown mode
);
    typedef enum logic [6:0] {
        S_RST   = 7'h01,
        S_IDLE  = 7'h02,
        S_LOW   = 7'h04,
        S_HIGH  = 7'h08,
        S_WAIT  = 7'h10,
        S_TX    = 7'h20,
        S_SHDN  = 7'h40
    } state_e;

    typedef struct packed {
        state_e                       st;
        logic [swire_pkg::CNT_W-1:0]  cnt;
        logic [swire_pkg::CNT_W-1:0]  sd_cnt;
        logic [7:0]                   shreg;
        logic [3:0]                   nbit;
        logic                         data_phase;
        logic                         is_write;
        logic                         oe;
        logic                         line_d;
        logic [7:0]                   cmd;
        logic [7:0]                   wdata;
        logic                         cmd_v;
        logic                         wdata_v;
        logic                         gcr;
        logic                         shdn;
    } dev_s;

    dev_s r_r, r_nxt;
    logic [7:0] fifo_data;
    logic       fifo_valid;
    logic       fifo_pop;

    swire_fifo #(
        .WIDTH (swire_pkg::DATA_W),
        .DEPTH (swire_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_data  (i_reply_data),
        .i_valid (i_reply_valid),
        .o_ready (o_reply_ready),
        .o_data  (fifo_data),
        .o_valid (fifo_valid),
        .i_ready (fifo_pop)
    );

    always_comb begin
        r_nxt = r_r;
        r_nxt.line_d  = bus.line;
        r_nxt.cmd_v   = 1'b0;
        r_nxt.wdata_v = 1'b0;
        fifo_pop      = 1'b0;
        r_nxt.cnt     = r_r.cnt + 1'b1;
        // Shutdown delay runs while supply stays below threshold
        if (i_asd_met && r_r.st != S_SHDN) begin
            r_nxt.sd_cnt = r_r.sd_cnt + 1'b1;
        end else begin
            r_nxt.sd_cnt = '0;
        end
        case (r_r.st)
            S_RST: begin
                r_nxt.oe = 1'b0;
                if (r_r.cnt >= swire_pkg::CNT_W'(GLOBAL_RESET_CYC - 1)) begin
                    r_nxt.gcr = 1'b0;
                    r_nxt.st  = S_IDLE;
                    r_nxt.cnt = '0;
                end
            end
            S_IDLE: begin
                r_nxt.cnt = '0;
                if (!bus.line) begin
                    r_nxt.st = S_LOW;
                end
            end
            S_LOW: begin
                if (bus.line) begin
                    // Short glitch is not a bit start
                    if (r_r.cnt < swire_pkg::CNT_W'(swire_pkg::FILTER_CYC)) begin
                        r_nxt.st = S_IDLE;
                    end else if (r_r.cnt >= swire_pkg::CNT_W'(swire_pkg::BREAK_DETECT_CYC)) begin
                        // Break restarts framing; next bits open a command
                        r_nxt.nbit       = '0;
                        r_nxt.data_phase = 1'b0;
                        r_nxt.st         = S_IDLE;
                    end else begin
                        // LSB first, threshold decides
                        r_nxt.shreg = {(r_r.cnt < swire_pkg::CNT_W'(swire_pkg::BIT_THRESHOLD_CYC)),
                                       r_r.shreg[7:1]};
                        r_nxt.nbit  = r_r.nbit + 1'b1;
                        r_nxt.st    = S_HIGH;
                    end
                end
            end
            S_HIGH: begin
                r_nxt.cnt = '0;
                if (r_r.nbit == 4'(swire_pkg::BYTE_BITS)) begin
                    r_nxt.nbit = '0;
                    if (!r_r.data_phase) begin
                        r_nxt.cmd      = r_r.shreg;
                        r_nxt.cmd_v    = 1'b1;
                        r_nxt.is_write = r_r.shreg[swire_pkg::DIR_BIT];
                        if (r_r.shreg[swire_pkg::DIR_BIT]) begin
                            r_nxt.data_phase = 1'b1;
                            r_nxt.st         = S_IDLE;
                        end else begin
                            r_nxt.st = S_WAIT;
                        end
                    end else begin
                        r_nxt.wdata      = r_r.shreg;
                        r_nxt.wdata_v    = 1'b1;
                        r_nxt.data_phase = 1'b0;
                        r_nxt.st         = S_IDLE;
                    end
                end else begin
                    r_nxt.st = S_IDLE;
                end
            end
            S_WAIT: begin
                // Reply delay timed from end of command bit's low phase
                if (r_r.cnt >= swire_pkg::CNT_W'(swire_pkg::DEV_REPLY_DELAY_CYC - 1)
                        && fifo_valid) begin
                    r_nxt.shreg = fifo_data;
                    fifo_pop    = 1'b1;
                    r_nxt.cnt   = '0;
                    r_nxt.nbit  = '0;
                    r_nxt.st    = S_TX;
                end
            end
            S_TX: begin
                // Pull low only; release is the only way high
                if (r_r.shreg[0]) begin
                    r_nxt.oe = r_r.cnt < swire_pkg::CNT_W'(swire_pkg::DEV_ONE_LOW_CYC);
                end else begin
                    r_nxt.oe = r_r.cnt < swire_pkg::CNT_W'(swire_pkg::DEV_ZERO_LOW_CYC);
                end
                if (r_r.cnt >= swire_pkg::CNT_W'(swire_pkg::DEV_BIT_PERIOD_CYC - 1)) begin
                    r_nxt.cnt   = '0;
                    r_nxt.shreg = {1'b0, r_r.shreg[7:1]};
                    r_nxt.nbit  = r_r.nbit + 1'b1;
                    if (r_r.nbit == 4'(swire_pkg::BYTE_BITS - 1)) begin
                        r_nxt.nbit = '0;
                        r_nxt.oe   = 1'b0;
                        r_nxt.st   = S_IDLE;
                    end
                end
            end
            S_SHDN: begin
                r_nxt.oe  = 1'b0;
                r_nxt.cnt = '0;
                // Any low level on the wire wakes device
                if (!bus.line) begin
                    r_nxt.shdn = 1'b0;
                    r_nxt.gcr  = 1'b1;
                    r_nxt.st   = S_RST;
                end
            end
            default: begin
                r_nxt.st = S_RST;
            end
        endcase
        if (r_r.st != S_SHDN && r_r.sd_cnt >= swire_pkg::CNT_W'(SHUTDOWN_CYC - 1)) begin
            r_nxt.st         = S_SHDN;
            r_nxt.shdn       = 1'b1;
            r_nxt.oe         = 1'b0;
            r_nxt.data_phase = 1'b0;
            r_nxt.nbit       = '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_r     <= '0;
            r_r.st  <= S_RST;
            r_r.gcr <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign bus.dev_oe          = r_r.oe;
    assign o_global_core_reset = r_r.gcr;
    assign o_cmd               = r_r.cmd;
    assign o_wdata             = r_r.wdata;
    assign o_cmd_valid         = r_r.cmd_v;
    assign o_wdata_valid       = r_r.wdata_v;
    assign o_shutdown          = r_r.shdn;
endmodule
`default_nettype wire

// >>> logic/swire_host.sv
// Purpose: Host end of the single-wire link
// Assumes: Device follows documented reply timing
// Notes:   One transaction per request; break optional
`timescale 1ns/1ps
`default_nettype none
module swire_host #(
    parameter int POR_READY_CYC = swire_pkg::POR_READY_CYC_DEF
) (
    input  wire logic       i_mclk,      // Clock
    input  wire logic       i_rst,       // Sync reset
    swire_if.host           bus,         // Shared wire
    input  wire logic       i_start,     // Start transaction
    input  wire logic       i_break,     // Send wake break first
    input  wire logic [7:0] i_cmd,       // Command, bit 7 = write
    input  wire logic [7:0] i_wdata,     // Write data
    output logic            o_busy,      // Transaction in progress
    output logic [7:0]      o_rdata,     // Read data
    output logic            o_done       // Transaction done pulse
);
    typedef enum logic [5:0] {
        H_POR  = 6'h01,
        H_IDLE = 6'h02,
        H_BRK  = 6'h04,
        H_TX   = 6'h08,
        H_RX   = 6'h10,
        H_RXHI = 6'h20
    } hst_e;
    typedef struct packed {
        hst_e                        st;
        logic [swire_pkg::CNT_W-1:0] cnt;
        logic [15:0]                 sh;
        logic [4:0]                  nbit;
        logic [4:0]                  nlen;
        logic                        rd;
        logic                        oe;
        logic [7:0]                  rdata;
        logic                        done;
    } host_s;
    host_s r_r, r_nxt;

    always_comb begin
        r_nxt      = r_r;
        r_nxt.done = 1'b0;
        r_nxt.cnt  = r_r.cnt + 1'b1;
        case (r_r.st)
            H_POR: begin
                if (r_r.cnt >= swire_pkg::CNT_W'(POR_READY_CYC - 1)) begin
                    r_nxt.st = H_IDLE;
                end
            end
            H_IDLE: begin
                r_nxt.cnt = '0;
                if (i_start) begin
                    r_nxt.sh   = {i_wdata, i_cmd};
                    r_nxt.rd   = !i_cmd[swire_pkg::DIR_BIT];
                    r_nxt.nlen = i_cmd[swire_pkg::DIR_BIT] ? 5'd16 : 5'd8;
                    r_nxt.nbit = '0;
                    r_nxt.st   = i_break ? H_BRK : H_TX;
                end
            end
            H_BRK: begin
                r_nxt.oe = r_r.cnt < swire_pkg::CNT_W'(swire_pkg::BREAK_CYC);
                if (r_r.cnt >= swire_pkg::CNT_W'(swire_pkg::BREAK_CYC
                                                 + swire_pkg::SLEEP_WAKE_CYC)) begin
                    r_nxt.cnt = '0;
                    r_nxt.st  = H_TX;
                end
            end
            H_TX: begin
                // LSB first; low time picks the bit value
                if (r_r.sh[0]) begin
                    r_nxt.oe = r_r.cnt < swire_pkg::CNT_W'(swire_pkg::HOST_ONE_LOW_CYC);
                end else begin
                    r_nxt.oe = r_r.cnt < swire_pkg::CNT_W'(swire_pkg::HOST_ZERO_LOW_CYC);
                end
                if (r_r.cnt >= swire_pkg::CNT_W'(swire_pkg::HOST_BIT_PERIOD_CYC - 1)) begin
                    r_nxt.cnt  = '0;
                    r_nxt.sh   = {1'b0, r_r.sh[15:1]};
                    r_nxt.nbit = r_r.nbit + 1'b1;
                    if (r_r.nbit == r_r.nlen - 5'd1) begin
                        r_nxt.nbit = '0;
                        if (r_r.rd) begin
                            r_nxt.st = H_RX;
                        end else begin
                            r_nxt.done = 1'b1;
                            r_nxt.st   = H_IDLE;
                        end
                    end
                end
            end
            H_RX: begin
                r_nxt.oe  = 1'b0;
                r_nxt.cnt = '0;
                if (!bus.line) begin
                    r_nxt.st = H_RXHI;
                end
            end
            H_RXHI: begin
                if (bus.line) begin
                    r_nxt.rdata = {(r_r.cnt < swire_pkg::CNT_W'(swire_pkg::BIT_THRESHOLD_CYC)),
                                   r_r.rdata[7:1]};
                    r_nxt.nbit  = r_r.nbit + 1'b1;
                    r_nxt.st    = H_RX;
                    if (r_r.nbit == 5'(swire_pkg::BYTE_BITS - 1)) begin
                        r_nxt.done = 1'b1;
                        r_nxt.st   = H_IDLE;
                    end
                end
            end
            default: begin
                r_nxt.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r_r    <= '0;
            r_r.st <= H_POR;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign bus.host_oe = r_r.oe;
    assign o_busy      = r_r.st != H_IDLE;
    assign o_rdata     = r_r.rdata;
    assign o_done      = r_r.done;
endmodule
`default_nettype wire

// >>> tb/swire_link_props.sv
// Purpose: Timing checks on the shared wire between host and device
// Assumes: One 10 MHz clock, sync active-high reset
// Notes:   Counters saturate; bounds are cycles of 100 ns
`timescale 1ns/1ps
`default_nettype none
module swire_link_props (
    input  wire logic i_mclk,   // Clock
    input  wire logic i_rst,    // Sync reset
    input  wire logic host_oe,  // Host pulls low
    input  wire logic dev_oe,   // Device pulls low
    input  wire logic line      // Resolved wire
);
    logic [15:0] dev_low_r;
    logic [15:0] dev_per_r;
    logic [15:0] host_low_r;
    logic [15:0] host_per_r;
    logic [15:0] host_idle_r;
    logic        dev_q_r;
    logic        host_q_r;

    function automatic logic [15:0] inc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            dev_low_r   <= 16'hffff;
            dev_per_r   <= 16'hffff;
            host_low_r  <= 16'hffff;
            host_per_r  <= 16'hffff;
            host_idle_r <= 16'hffff;
            dev_q_r     <= 1'b0;
            host_q_r    <= 1'b0;
        end else begin
            dev_q_r     <= dev_oe;
            host_q_r    <= host_oe;
            dev_low_r   <= dev_oe ? inc(dev_low_r) : 16'h0000;
            host_low_r  <= host_oe ? inc(host_low_r) : 16'h0000;
            host_idle_r <= host_oe ? 16'h0000 : inc(host_idle_r);
            dev_per_r   <= (dev_oe && !dev_q_r) ? 16'h0001 : inc(dev_per_r);
            host_per_r  <= (host_oe && !host_q_r) ? 16'h0001 : inc(host_per_r);
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    property p_no_overlap; !(host_oe && dev_oe); endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("Both ends pull the wire at once");
    property p_dev_low; $fell(dev_oe) |-> dev_low_r inside {[390:430], [1060:1160]}; endproperty
    a_dev_low: assert property (p_dev_low)
        else $error("Device low time out of range");
    property p_dev_period; $rose(dev_oe) && dev_per_r < 16'd4000 |-> dev_per_r inside {[1970:2170]};
    endproperty
    a_dev_period: assert property (p_dev_period)
        else $error("Device bit period out of range");
    property p_reply_delay; $rose(dev_oe) && host_idle_r < dev_per_r
        |-> host_idle_r inside {[2110:2330]}; endproperty
    a_reply_delay: assert property (p_reply_delay)
        else $error("Reply delay out of range");
    property p_host_low; $fell(host_oe)
        |-> host_low_r inside {[50:500], [860:1450], [1900:65535]}; endproperty
    a_host_low: assert property (p_host_low)
        else $error("Host low time out of range");
    property p_host_period; $rose(host_oe) |-> host_per_r >= 16'd1900; endproperty
    a_host_period: assert property (p_host_period)
        else $error("Host bit period too short");
    property p_dev_release; dev_oe |-> dev_low_r < 16'd1160; endproperty
    a_dev_release: assert property (p_dev_release)
        else $error("Device holds the wire too long");
    property p_idle_high; !host_oe && !dev_oe |-> line; endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("Wire not high while released");
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Both link ends joined; second device driven by bench
// Assumes: Shortened reset and shutdown counts
// Notes:   Second wire carries glitch, shutdown and wake cases
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       i_mclk = 1'b0;
    logic       i_rst, start, brk, busy, done, rv, rr, gcr, cv, wv;
    logic       asd1, asd2, rr2, gcr2, cv2, wv2, sd, sd2;
    logic [7:0] cmd, wdata, rdata, rd, dcmd, dwd, cmd2, wd2;
    int         bad_count = 0;
    int         n_tests = 0;
    int         n_cv = 0;
    int         n_wv = 0;
    int         n_cv2 = 0;

    swire_if swire_if_inst ();
    swire_if swire_if_inst_b ();
    swire_host #(.POR_READY_CYC(50)) swire_host_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .bus(swire_if_inst), .i_start(start), .i_break(brk), .i_cmd(cmd), .i_wdata(wdata),
        .o_busy(busy), .o_rdata(rdata), .o_done(done));
    swire_device #(.GLOBAL_RESET_CYC(50), .SHUTDOWN_CYC(200)) swire_device_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .bus(swire_if_inst), .i_asd_met(asd1),
        .i_reply_data(rd), .i_reply_valid(rv), .o_reply_ready(rr), .o_global_core_reset(gcr),
        .o_cmd(dcmd), .o_wdata(dwd), .o_cmd_valid(cv), .o_wdata_valid(wv), .o_shutdown(sd));
    swire_device #(.GLOBAL_RESET_CYC(50), .SHUTDOWN_CYC(200)) swire_device_inst_b (
        .i_mclk(i_mclk), .i_rst(i_rst), .bus(swire_if_inst_b), .i_asd_met(asd2),
        .i_reply_data(rd), .i_reply_valid(rv), .o_reply_ready(rr2),
        .o_global_core_reset(gcr2), .o_cmd(cmd2), .o_wdata(wd2), .o_cmd_valid(cv2),
        .o_wdata_valid(wv2), .o_shutdown(sd2));
    swire_link_props swire_link_props_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .host_oe(swire_if_inst.host_oe), .dev_oe(swire_if_inst.dev_oe),
        .line(swire_if_inst.line));

    initial forever #50 i_mclk = ~i_mclk;

    always @(posedge i_mclk) begin
        if (cv === 1'b1) n_cv++;
        if (wv === 1'b1) n_wv++;
        if (cv2 === 1'b1) n_cv2++;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic host_txn(input logic b, input logic [7:0] c, input logic [7:0] d);
        int i;
        @(posedge i_mclk);
        for (i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge i_mclk);
        brk <= b;
        cmd <= c;
        wdata <= d;
        start <= 1'b1;
        @(posedge i_mclk);
        start <= 1'b0;
        for (i = 0; i < 60000; i++) begin
            @(posedge i_mclk);
            #1;
            if (done === 1'b1) break;
        end
    endtask

    task automatic wire_low(input int low, input int rest);
        @(posedge i_mclk);
        swire_if_inst_b.host_oe <= 1'b1;
        repeat (low) @(posedge i_mclk);
        swire_if_inst_b.host_oe <= 1'b0;
        repeat (rest) @(posedge i_mclk);
    endtask

    initial begin
        repeat (90000) @(posedge i_mclk);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        i_rst = 1'b1;
        {start, brk, rv, asd2, asd1} = 5'h00;
        {cmd, wdata, rd} = 24'h000000;
        swire_if_inst_b.host_oe = 1'b0;
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
        repeat (45) @(posedge i_mclk);
        #1 check(8'(gcr), 8'h01);
        repeat (15) @(posedge i_mclk);
        #1 check(8'(gcr), 8'h00);
        $display("core reset test done");
        fork
            begin
                host_txn(1'b0, 8'h85, 8'h3c);
                check(dcmd, 8'h85);
                check(dwd, 8'h3c);
                check(8'(n_wv), 8'h01);
                $display("write test done");
                for (int i = 0; i < 16; i++) begin
                    @(posedge i_mclk);
                    rd <= 8'h10 + 8'(i);
                    rv <= 1'b1;
                end
                @(posedge i_mclk);
                rv <= 1'b0;
                #1 check(8'(rr), 8'h00);
                host_txn(1'b1, 8'h07, 8'h00);
                check(rdata, 8'h10);
                check(8'(n_cv), 8'h02);
                check(8'(n_wv), 8'h01);
                check(8'(rr), 8'h01);
                $display("read test done");
            end
            begin
                @(posedge i_mclk);
                asd2 <= 1'b1;
                repeat (100) @(posedge i_mclk);
                #1 check(8'(sd2), 8'h00);
                repeat (150) @(posedge i_mclk);
                #1 check(8'(sd2), 8'h01);
                asd2 <= 1'b0;
                wire_low(30, 0);
                #1 check(8'(gcr2), 8'h01);
                repeat (200) @(posedge i_mclk);
                #1 check(8'(gcr2), 8'h00);
                check(8'(sd2), 8'h00);
                $display("shutdown test done");
                wire_low(10, 100);
                for (int i = 0; i < 8; i++) begin
                    if (8'hc3 >> i & 8'h01) wire_low(200, 1700);
                    else wire_low(1150, 750);
                end
                repeat (10) @(posedge i_mclk);
                #1 check(cmd2, 8'hc3);
                check(8'(n_cv2), 8'h01);
                $display("glitch test done");
            end
        join
        check(8'(rr2), 8'h00);
        check(8'(sd), 8'h00);
        check(8'(busy), 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
